// ---- verilog/fbg_map.svh ----
// Constants of the fieldbus parameter gateway: object indices, codes,
// host register offsets and timing counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FBG_MAP_SVH
`define FBG_MAP_SVH
`define FBG_OBJ_RD_REQ  16'h2040
`define FBG_OBJ_RD_RSP  16'h2140
`define FBG_OBJ_WR_REQ  16'h2050
`define FBG_OBJ_WR_RSP  16'h2150
`define FBG_OBJ_PDO_RES 16'h2155
`define FBG_OBJ_RAM_ENT 16'h2060
`define FBG_OBJ_ROM_ENT 16'h2070
`define FBG_OBJ_ENT_RSP 16'h2160
`define FBG_OBJ_LINK0   16'h2180
`define FBG_SUB_0       8'h00
`define FBG_SUB_1       8'h01
`define FBG_SUB_2       8'h02
`define FBG_SAVE_WORD   32'h6576_6173
`define FBG_MAX_LINKS   4'h4
`define FBG_RES_OK      16'h0000
`define FBG_RES_ERR     16'h0001
`define FBG_TX_COS      8'hFE
`define FBG_TICK_CYC    40000
`define FBG_GAP_CYC     16'h0100
`define FBG_WB_OBJ      8'h00
`define FBG_WB_DLO      8'h04
`define FBG_WB_DHI      8'h08
`define FBG_WB_CTRL     8'h0C
`define FBG_WB_STAT     8'h10
`define FBG_WB_RDAT     8'h14
`define FBG_WB_TXD      8'h18
`define FBG_WB_TXCNT    8'h1C
`endif

// ---- verilog/fbg_pkg.sv ----
// Types shared by both ends of the fieldbus parameter gateway.
// Assumes fbg_map.svh is on the include path.
`include "fbg_map.svh"
package fbg_pkg;
	// Orders that the gateway gives to the drive register space.
	typedef enum logic [2:0] {
		FBG_CMD_RD, FBG_CMD_WR, FBG_CMD_WR_NOW, FBG_CMD_ENT_RAM,
		FBG_CMD_ENT_ROM
	} fbg_drv_cmd_t;
	// Device sequencer states.
	typedef enum logic [1:0] {DS_IDLE, DS_DRV, DS_NEXT} fbg_dstate_t;
	// What a finished drive transaction updates.
	typedef enum logic [2:0] {
		K_RD, K_WR, K_RAM, K_ROM, K_SDO_RD, K_SDO_WR, K_PDO
	} fbg_kind_t;
	// Host controller states.
	typedef enum logic [1:0] {HS_IDLE, HS_REQ, HS_GAP} fbg_hstate_t;
	// Whole state of the device end.
	typedef struct packed {
		fbg_dstate_t       st;
		fbg_kind_t         kind;
		logic [15:0]       rd_addr, rd_val, wr_res, ent_res;
		logic [23:0]       pdo_res;
		logic              pdo_seen, pdo_upd;
		logic [3:0][15:0]  link_addr;
		logic [63:0]       pdo_data;
		logic [1:0]        pdo_obj;
		logic [2:0]        pdo_rem, bad_cnt;
		logic [10:0]       pdo_cob;
		logic              drv_req;
		fbg_drv_cmd_t      drv_cmd;
		logic [15:0]       drv_addr, drv_wdata;
		logic              done, err;
		logic [31:0]       rdata;
	} fbg_dev_st_t;
	// Whole state of the transmit trigger.
	typedef struct packed {
		logic [15:0] tick, ms;
		logic        tx;
		logic [31:0] tx_data;
	} fbg_cos_st_t;
	// Whole state of the host end.
	typedef struct packed {
		fbg_hstate_t st;
		logic [15:0] gap;
		logic [31:0] obj, dlo, dhi, ctrl, rdata, txd;
		logic [15:0] txcnt;
		logic        done, err;
		logic        m_valid, m_rtr;
		logic        wb_ack;
		logic [31:0] wb_rdat;
	} fbg_host_st_t;
endpackage

// ---- verilog/fbg_if.sv ----
// Link between the fieldbus master end and the gateway device end.
// Assumes both ends share one clock; the bench joins the two modports.
`timescale 1ns/1ps
interface fbg_if;
	logic        m_valid;  // Request held until s_done.
	logic [15:0] m_idx;    // Object index.
	logic [7:0]  m_sub;    // Subindex.
	logic        m_we;     // Write access.
	logic        m_pdo;    // Carried by process data, not service data.
	logic [10:0] m_cob;    // Identifier of the carrying message.
	logic [2:0]  m_cnt;    // Entries in a parameter batch.
	logic [63:0] m_data;   // Write data, entry k in bits 16k+15:16k.
	logic        m_rtr;    // One-cycle remote transmit request.
	logic        s_done;   // One-cycle answer pulse.
	logic        s_err;    // Error answer, valid with s_done.
	logic [31:0] s_rdata;  // Read data, valid with s_done.
	logic        s_tx;     // One-cycle transmit event.
	logic [31:0] s_tx_data;  // Transmitted write-result value.
	modport dev (input m_valid, m_idx, m_sub, m_we, m_pdo, m_cob, m_cnt,
		m_data, m_rtr, output s_done, s_err, s_rdata, s_tx, s_tx_data);
	modport host (output m_valid, m_idx, m_sub, m_we, m_pdo, m_cob, m_cnt,
		m_data, m_rtr, input s_done, s_err, s_rdata, s_tx, s_tx_data);
endinterface

// ---- verilog/fbg_cos.sv ----
// Transmit trigger for the write-result object: change, timer or request.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/1ps
`include "fbg_map.svh"
module fbg_cos #(
	parameter int TICK_CYC = `FBG_TICK_CYC  // Cycles in 1 ms.
) (
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        upd,        // Value refreshed this cycle.
	input  wire logic [31:0] val,        // Value to send.
	input  wire logic        rtr,        // Remote request pulse.
	input  wire logic [7:0]  tx_type,    // Transmission type.
	input  wire logic [15:0] period_ms,  // Event timer, 0 is off.
	output logic             tx,
	output logic [31:0]      tx_data
);
	import fbg_pkg::*;
	fbg_cos_st_t s_ff, nxt_s;  // Whole state.
	logic        ms_tick;      // Millisecond strobe.
	logic        timer_hit;    // Event timer expiry.

	// Any refresh counts as a change so every accepted batch is answered.
	always_comb begin
		nxt_s = s_ff;
		nxt_s.tx = 1'b0;
		ms_tick = (s_ff.tick == 16'(TICK_CYC - 1));
		nxt_s.tick = ms_tick ? 16'h0000 : s_ff.tick + 16'h0001;
		timer_hit = ms_tick && (period_ms != 16'h0000) &&
			(s_ff.ms + 16'h0001 >= period_ms);
		if ((upd && tx_type == `FBG_TX_COS) || timer_hit ||
				rtr) begin
			nxt_s.tx = 1'b1;
			nxt_s.tx_data = val;
			nxt_s.ms = 16'h0000;  // A change event restarts the timer.
		end else if (ms_tick) begin
			nxt_s.ms = s_ff.ms + 16'h0001;
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign tx = s_ff.tx;
	assign tx_data = s_ff.tx_data;
endmodule

// ---- verilog/fbg_dev.sv ----
// Device end of the fieldbus parameter gateway: turns object accesses
// into drive register transactions and keeps the response objects.
// Assumes the drive answers each held drv_req with one drv_ack pulse and
// applies write, commit and initialization semantics on its own side.
`timescale 1ns/1ps
`include "fbg_map.svh"
// Notes on behaviour
// - Read request address yields value in response.
// - Read objects accepted over service or process data.
// - Write request carries value and address; result kept.
// - Pending writes activate on RAM commit; ROM stores.
// - Commit only when the word save arrives.
// - RAM commit result kept for the master.
// - One commit activates all pending writes.
// - Write and commit objects mappable to process data.
// - Linked object access reaches drive; reply carries errors.
// - Linked values sent on request, timer, change.
// - Process data writes apply at once.
// - At most four linked entries per message.
// - Invalid entries dropped, valid ones still written.
// - Write result holds identifier and invalid count.
// - Master maps write result with change type.
// - Write result changes only from process data.
// - Reading write result before any batch errors.
// - Initialization needs commit after init register write.
// - Master clears enter setting, writes code, commits.
// - Master waits after writes and commits.
// - Change type sends whenever mapped value changes.
module fbg_dev #(
	parameter int TICK_CYC = `FBG_TICK_CYC  // Cycles in 1 ms.
) (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	fbg_if.dev                        link,
	output fbg_pkg::fbg_drv_cmd_t     drv_cmd,
	output logic                      drv_req,
	output logic [15:0]               drv_addr,
	output logic [15:0]               drv_wdata,
	input  wire logic                 drv_ack,
	input  wire logic                 drv_err,
	input  wire logic [15:0]          drv_rdata,
	input  wire logic [7:0]           tx_type,
	input  wire logic [15:0]          tx_period_ms
);
	import fbg_pkg::*;
	fbg_dev_st_t s_ff, nxt_s;  // Whole state of the device end.
	logic        link_hit;     // Index falls on a linked object.
	logic [1:0]  link_j;       // Which linked object.
	logic        batch_bad;    // Batch empty or too long for the linked block.
	logic        is_save;      // Commit password present.
	logic [2:0]  nxt_bad;      // Invalid count including this entry.

	assign link_hit = (link.m_idx[15:2] == 14'(`FBG_OBJ_LINK0 >> 2));
	assign link_j = link.m_idx[1:0];
	// Longer batches could not be written from one message.
	assign batch_bad = (link.m_cnt == 3'h0) ||
		(({2'b00, link_j} + {1'b0, link.m_cnt}) > `FBG_MAX_LINKS);
	assign is_save = (link.m_data[31:0] == `FBG_SAVE_WORD);
	assign nxt_bad = s_ff.bad_cnt + {2'b00, drv_err};

	// Start one drive transaction and remember what it answers.
	function automatic fbg_dev_st_t issue(fbg_dev_st_t s, fbg_drv_cmd_t c,
			logic [15:0] a, logic [15:0] d, fbg_kind_t k);
		s.st = DS_DRV;
		s.drv_req = 1'b1;
		s.drv_cmd = c;
		s.drv_addr = a;
		s.drv_wdata = d;
		s.kind = k;
		return s;
	endfunction

	// Answer the master and return to idle.
	function automatic fbg_dev_st_t fin(fbg_dev_st_t s, logic e,
			logic [31:0] r);
		s.st = DS_IDLE;
		s.done = 1'b1;
		s.err = e;
		s.rdata = r;
		return s;
	endfunction

	// Sequencer: decode in idle, wait on the drive, walk a batch.
	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.pdo_upd = 1'b0;
		unique case (s_ff.st)
		DS_IDLE: begin
			// The done flag blocks a second take of the same request.
			if (link.m_valid && !s_ff.done) begin
				// Service and process data decode alike here.
				if (link.m_idx == `FBG_OBJ_RD_REQ &&
						link.m_sub == `FBG_SUB_0) begin
					if (link.m_we) begin
						nxt_s.rd_addr = link.m_data[15:0];
						nxt_s = issue(nxt_s, FBG_CMD_RD, link.m_data[15:0],
							16'h0000, K_RD);
					end else begin
						nxt_s = fin(nxt_s, 1'b0, {16'h0000, s_ff.rd_addr});
					end
				end else if (link.m_idx == `FBG_OBJ_RD_RSP &&
						link.m_sub == `FBG_SUB_1 && !link.m_we) begin
					nxt_s = fin(nxt_s, 1'b0, {16'h0000, s_ff.rd_val});
				end else if (link.m_idx == `FBG_OBJ_WR_REQ &&
						link.m_sub == `FBG_SUB_1 && link.m_we) begin
					// Address in the upper half, value in the lower.
					nxt_s = issue(nxt_s, FBG_CMD_WR, link.m_data[31:16],
						link.m_data[15:0], K_WR);
				end else if ((link.m_idx == `FBG_OBJ_RAM_ENT ||
						link.m_idx == `FBG_OBJ_ROM_ENT) &&
						link.m_sub == `FBG_SUB_1 && link.m_we) begin
					// Any other word is taken but has no effect.
					if (!is_save) begin
						nxt_s = fin(nxt_s, 1'b0, 32'h0000_0000);
					end else if (link.m_idx == `FBG_OBJ_RAM_ENT) begin
						// The drive activates every pending change at once.
						nxt_s = issue(nxt_s, FBG_CMD_ENT_RAM, 16'h0000,
							16'h0000, K_RAM);
					end else begin
						nxt_s = issue(nxt_s, FBG_CMD_ENT_ROM, 16'h0000,
							16'h0000, K_ROM);
					end
				end else if (link.m_idx == `FBG_OBJ_WR_RSP &&
						link.m_sub == `FBG_SUB_1 && !link.m_we) begin
					nxt_s = fin(nxt_s, 1'b0, {16'h0000, s_ff.wr_res});
				end else if (link.m_idx == `FBG_OBJ_ENT_RSP &&
						link.m_sub == `FBG_SUB_0 && !link.m_we) begin
					nxt_s = fin(nxt_s, 1'b0, {16'h0000, s_ff.ent_res});
				end else if (link.m_idx == `FBG_OBJ_PDO_RES &&
						link.m_sub == `FBG_SUB_0 && !link.m_we) begin
					// Nothing to report before the first batch.
					nxt_s = fin(nxt_s, !s_ff.pdo_seen,
						{8'h00, s_ff.pdo_res});
				end else if (link_hit && link.m_sub == `FBG_SUB_2) begin
					// Link address of a linked object.
					if (link.m_we) begin
						nxt_s.link_addr[link_j] = link.m_data[15:0];
						nxt_s = fin(nxt_s, 1'b0, 32'h0000_0000);
					end else begin
						nxt_s = fin(nxt_s, 1'b0,
							{16'h0000, s_ff.link_addr[link_j]});
					end
				end else if (link_hit && link.m_sub == `FBG_SUB_1) begin
					if (link.m_we && link.m_pdo) begin
						if (batch_bad) begin
							nxt_s = fin(nxt_s, 1'b1, 32'h0000_0000);
						end else begin
							nxt_s.pdo_data = link.m_data;
							nxt_s.pdo_obj = link_j;
							nxt_s.pdo_rem = link.m_cnt;
							nxt_s.pdo_cob = link.m_cob;
							nxt_s.bad_cnt = 3'h0;
							nxt_s = issue(nxt_s, FBG_CMD_WR_NOW,
								s_ff.link_addr[link_j], link.m_data[15:0],
								K_PDO);
						end
					end else if (link.m_we) begin
						nxt_s = issue(nxt_s, FBG_CMD_WR,
							s_ff.link_addr[link_j], link.m_data[15:0],
							K_SDO_WR);
					end else begin
						nxt_s = issue(nxt_s, FBG_CMD_RD,
							s_ff.link_addr[link_j], 16'h0000, K_SDO_RD);
					end
				end else begin
					// Unknown object or access answers with an error.
					nxt_s = fin(nxt_s, 1'b1, 32'h0000_0000);
				end
			end
		end
		DS_DRV: begin
			// Response objects change only on the drive's answer.
			if (drv_ack) begin
				nxt_s.drv_req = 1'b0;
				unique case (s_ff.kind)
				K_RD: begin
					nxt_s.rd_val = drv_rdata;
					nxt_s = fin(nxt_s, 1'b0, 32'h0000_0000);
				end
				K_WR: begin
					nxt_s.wr_res = drv_err ? `FBG_RES_ERR : `FBG_RES_OK;
					nxt_s = fin(nxt_s, 1'b0, 32'h0000_0000);
				end
				K_RAM: begin
					nxt_s.ent_res = drv_err ? `FBG_RES_ERR : `FBG_RES_OK;
					nxt_s = fin(nxt_s, 1'b0, 32'h0000_0000);
				end
				K_ROM: begin
					nxt_s = fin(nxt_s, drv_err, 32'h0000_0000);
				end
				K_SDO_RD: begin
					nxt_s = fin(nxt_s, drv_err, {16'h0000, drv_rdata});
				end
				K_SDO_WR: begin
					// Service data leaves the write result untouched.
					nxt_s = fin(nxt_s, drv_err, 32'h0000_0000);
				end
				K_PDO: begin
					// A refused entry only bumps the count.
					nxt_s.bad_cnt = nxt_bad;
					if (s_ff.pdo_rem > 3'h1) begin
						nxt_s.pdo_rem = s_ff.pdo_rem - 3'h1;
						nxt_s.pdo_obj = s_ff.pdo_obj + 2'h1;
						nxt_s.pdo_data = {16'h0000, s_ff.pdo_data[63:16]};
						nxt_s.st = DS_NEXT;
					end else begin
						nxt_s.pdo_res = {5'h00, nxt_bad, 5'h00,
							s_ff.pdo_cob[10:8], s_ff.pdo_cob[7:0]};
						nxt_s.pdo_seen = 1'b1;
						nxt_s.pdo_upd = 1'b1;
						nxt_s = fin(nxt_s, 1'b0, 32'h0000_0000);
					end
				end
				default: nxt_s = fin(nxt_s, 1'b1, 32'h0000_0000);
				endcase
			end
		end
		DS_NEXT: begin
			// Request drops for a cycle between batch entries.
			nxt_s = issue(nxt_s, FBG_CMD_WR_NOW,
				s_ff.link_addr[s_ff.pdo_obj], s_ff.pdo_data[15:0],
				K_PDO);
		end
		default: nxt_s.st = DS_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Write result goes out by its own trigger.
	fbg_cos #(
		.TICK_CYC (TICK_CYC)
	) u_cos (
		.clk       (clk),
		.rstn      (rstn),
		.upd       (s_ff.pdo_upd),
		.val       ({8'h00, s_ff.pdo_res}),
		.rtr       (link.m_rtr),
		.tx_type   (tx_type),
		.period_ms (tx_period_ms),
		.tx        (link.s_tx),
		.tx_data   (link.s_tx_data)
	);

	assign link.s_done = s_ff.done;
	assign link.s_err = s_ff.err;
	assign link.s_rdata = s_ff.rdata;
	assign drv_req = s_ff.drv_req;
	assign drv_cmd = s_ff.drv_cmd;
	assign drv_addr = s_ff.drv_addr;
	assign drv_wdata = s_ff.drv_wdata;
endmodule

// ---- verilog/fbg_host.sv ----
// Master end of the gateway link: software orders object accesses
// through Wishbone registers and reads answers and transmit events.
// Assumes a classic Wishbone master on the same clock.
`timescale 1ns/1ps
`include "fbg_map.svh"
module fbg_host (
	input  wire logic        clk,
	input  wire logic        rstn,
	fbg_if.host              link,
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_w,
	output logic [31:0]      wb_dat_r,
	output logic             wb_ack
);
	import fbg_pkg::*;
	fbg_host_st_t s_ff, nxt_s;  // Whole state of the host end.
	logic         acc;          // New bus access this cycle.
	logic [31:0]  ctrl_w;       // Control word after byte lanes.

	// Byte-lane merge of a write.
	function automatic logic [31:0] wmerge(logic [31:0] o, logic [31:0] d,
			logic [3:0] sel);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	assign acc = wb_cyc && wb_stb && !s_ff.wb_ack;
	assign ctrl_w = wmerge(32'h0000_0000, wb_dat_w, wb_sel);

	// Bus slave, request sequencer and spacing after writes.
	always_comb begin
		nxt_s = s_ff;
		nxt_s.wb_ack = acc;
		nxt_s.m_rtr = 1'b0;
		if (acc && wb_we) begin
			unique case (wb_adr)
			`FBG_WB_OBJ: nxt_s.obj = wmerge(s_ff.obj, wb_dat_w, wb_sel);
			`FBG_WB_DLO: nxt_s.dlo = wmerge(s_ff.dlo, wb_dat_w, wb_sel);
			`FBG_WB_DHI: nxt_s.dhi = wmerge(s_ff.dhi, wb_dat_w, wb_sel);
			`FBG_WB_CTRL: begin
				nxt_s.m_rtr = ctrl_w[3];
				// A start while busy or spacing is dropped.
				if (ctrl_w[0] && s_ff.st == HS_IDLE) begin
					nxt_s.ctrl = ctrl_w;
					nxt_s.m_valid = 1'b1;
					nxt_s.done = 1'b0;
					nxt_s.st = HS_REQ;
				end
			end
			default: begin
			end
			endcase
		end else if (acc) begin
			unique case (wb_adr)
			`FBG_WB_OBJ:   nxt_s.wb_rdat = s_ff.obj;
			`FBG_WB_DLO:   nxt_s.wb_rdat = s_ff.dlo;
			`FBG_WB_DHI:   nxt_s.wb_rdat = s_ff.dhi;
			`FBG_WB_CTRL:  nxt_s.wb_rdat = s_ff.ctrl;
			`FBG_WB_STAT:  nxt_s.wb_rdat = {29'h0000_0000, s_ff.err,
				s_ff.done, (s_ff.st != HS_IDLE)};
			`FBG_WB_RDAT:  nxt_s.wb_rdat = s_ff.rdata;
			`FBG_WB_TXD:   nxt_s.wb_rdat = s_ff.txd;
			`FBG_WB_TXCNT: nxt_s.wb_rdat = {16'h0000, s_ff.txcnt};
			default:       nxt_s.wb_rdat = 32'h0000_0000;
			endcase
		end
		unique case (s_ff.st)
		HS_IDLE: begin
		end
		HS_REQ: begin
			if (link.s_done) begin
				nxt_s.m_valid = 1'b0;
				nxt_s.rdata = link.s_rdata;
				nxt_s.err = link.s_err;
				nxt_s.done = 1'b1;
				// Writes and commits leave the drive time to settle.
				nxt_s.st = s_ff.ctrl[1] ? HS_GAP : HS_IDLE;
				nxt_s.gap = `FBG_GAP_CYC;
			end
		end
		HS_GAP: begin
			nxt_s.gap = s_ff.gap - 16'h0001;
			if (s_ff.gap == 16'h0001) begin
				nxt_s.st = HS_IDLE;
			end
		end
		default: nxt_s.st = HS_IDLE;
		endcase
		// Each answer of a mapped write result is counted.
		if (link.s_tx) begin
			nxt_s.txd = link.s_tx_data;
			nxt_s.txcnt = s_ff.txcnt + 16'h0001;
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign link.m_valid = s_ff.m_valid;
	assign link.m_rtr = s_ff.m_rtr;
	assign link.m_idx = s_ff.obj[31:16];
	assign link.m_sub = s_ff.obj[15:8];
	assign link.m_cnt = s_ff.obj[2:0];
	assign link.m_data = {s_ff.dhi, s_ff.dlo};
	assign link.m_we = s_ff.ctrl[1];
	assign link.m_pdo = s_ff.ctrl[2];
	assign link.m_cob = s_ff.ctrl[26:16];
	assign wb_dat_r = s_ff.wb_rdat;
	assign wb_ack = s_ff.wb_ack;
endmodule

// ---- testbench/fbg_properties.sv ----
// Checker of the gateway link; it sees only the interface signals.
// Assumes one clock and both ends joined by one link.
`timescale 1ns/1ps
module fbg_properties (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        m_valid,
	input wire logic [15:0] m_idx,
	input wire logic [7:0]  m_sub,
	input wire logic        m_we,
	input wire logic        m_pdo,
	input wire logic [10:0] m_cob,
	input wire logic [2:0]  m_cnt,
	input wire logic [63:0] m_data,
	input wire logic        m_rtr,
	input wire logic        s_done,
	input wire logic        s_err,
	input wire logic [31:0] s_rdata,
	input wire logic        s_tx,
	input wire logic [31:0] s_tx_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [8:0]  gap_ff;  // Cycles since a write answer, saturating.
	logic        seen_ff;  // A good batch has been answered.
	logic [10:0] cob_ff;  // Identifier of that batch.
	wire         batch = m_pdo & m_we & (m_idx[15:2] == 14'h0860) &
		(m_sub == 8'h01);
	// Helper state follows the answers; it saturates so it never wraps.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			gap_ff  <= 9'h1ff;
			seen_ff <= 1'b0;
			cob_ff  <= 11'h000;
		end else begin
			if (s_done && m_we)
				gap_ff <= 9'h000;
			else if (gap_ff != 9'h1ff)
				gap_ff <= gap_ff + 9'h001;
			if (s_done && batch && !s_err) begin
				seen_ff <= 1'b1;
				cob_ff  <= m_cob;
			end
		end
	end
	sequence batch_done_s;
		s_done && batch && !s_err;
	endsequence
	done_pulse_a: assert property (s_done |=> !s_done)
		else $error("answer pulse too long");
	hold_req_a: assert property (m_valid && !s_done |=> m_valid &&
		$stable(m_idx) && $stable(m_we)) else $error("request dropped");
	release_a: assert property (s_done |=> !m_valid)
		else $error("request held after answer");
	gap_wait_a: assert property ($rose(m_valid) |-> gap_ff >= 9'h0ff)
		else $error("request too soon after write");
	early_result_a: assert property (s_done && !m_we &&
		m_idx == 16'h2155 && !seen_ff |-> s_err) else $error("no error");
	batch_size_a: assert property (s_done && batch &&
		(m_cnt == 3'h0 ||
		{2'h0, m_idx[1:0]} + {1'h0, m_cnt} > 4'h4) |-> s_err)
		else $error("oversized batch accepted");
	save_word_a: assert property (s_done && m_we && m_sub == 8'h01 &&
		(m_idx == 16'h2060 || m_idx == 16'h2070) &&
		m_data[31:0] != 32'h6576_6173 |-> !s_err) else $error("bad word");
	rtr_send_a: assert property (m_rtr |-> ##[1:2] s_tx)
		else $error("no send on remote request");
	result_form_a: assert property (s_tx && seen_ff |->
		s_tx_data[31:19] == 13'h0000 && s_tx_data[15:11] == 5'h00 &&
		s_tx_data[10:0] == cob_ff) else $error("bad write result");
	cover property (batch_done_s ##[1:2] s_tx);
endmodule

// ---- testbench/fieldbus_param_gateway_tb.sv ----
// Bench: Wishbone master on the host end, drive model on the device end.
// Assumes a 20-cycle millisecond in the device for short timer runs.
`timescale 1ns/1ps
module fieldbus_param_gateway_tb;
	import fbg_pkg::*;
	localparam int          TICK = 20;  // Shortened millisecond.
	localparam logic [31:0] SAVE = 32'h6576_6173;  // Commit word.
	logic         clk, rstn, wb_cyc, wb_stb, wb_we, wb_ack, e, p;
	logic [7:0]   wb_adr, tx_type;
	logic [3:0]   wb_sel;
	logic [31:0]  wb_dat_w, wb_dat_r, rd, q, t;
	fbg_drv_cmd_t drv_cmd, last_cmd;
	logic         drv_req, drv_ack, drv_err;
	logic [15:0]  drv_addr, drv_wdata, drv_rdata, last_addr, last_dat;
	logic [15:0]  tx_period_ms, a, v;
	logic [63:0]  d;
	logic [10:0]  cob;
	int           error_cnt, checked, n_cmd, n_bad, n0, nb, b;
	fbg_if link ();
	fbg_host i_fbg_host (.clk(clk), .rstn(rstn), .link(link.host),
		.wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
		.wb_ack(wb_ack));
	fbg_dev #(.TICK_CYC(TICK)) i_fbg_dev (.clk(clk), .rstn(rstn),
		.link(link.dev), .drv_cmd(drv_cmd), .drv_req(drv_req),
		.drv_addr(drv_addr), .drv_wdata(drv_wdata), .drv_ack(drv_ack),
		.drv_err(drv_err), .drv_rdata(drv_rdata), .tx_type(tx_type),
		.tx_period_ms(tx_period_ms));
	fbg_properties i_fbg_properties (.clk(clk), .rstn(rstn),
		.m_valid(link.m_valid), .m_idx(link.m_idx), .m_sub(link.m_sub),
		.m_we(link.m_we), .m_pdo(link.m_pdo), .m_cob(link.m_cob),
		.m_cnt(link.m_cnt), .m_data(link.m_data), .m_rtr(link.m_rtr),
		.s_done(link.s_done), .s_err(link.s_err),
		.s_rdata(link.s_rdata), .s_tx(link.s_tx),
		.s_tx_data(link.s_tx_data));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Read value that the drive model gives for an address.
	function automatic logic [15:0] exp_rd(input logic [15:0] ad);
		return ad ^ 16'ha5c3;
	endfunction
	// Write result word: identifier and count of refused entries.
	function automatic logic [31:0] exp_res(input logic [10:0] c,
		input logic [2:0] n);
		return {8'h00, 5'h00, n, 5'h00, c};
	endfunction
	// Drive model: answers after a random wait. A value with bit 15 set
	// counts as out of range, so such a write is refused.
	initial begin
		{drv_ack, drv_err, drv_rdata, n_cmd, n_bad} = '0;
		forever begin
			@(posedge clk);
			if (drv_req === 1'b1) begin
				repeat ($urandom_range(2, 0)) @(posedge clk);
				n_cmd++;
				last_cmd = drv_cmd;
				last_addr = drv_addr;
				last_dat = drv_wdata;
				e = drv_cmd inside {FBG_CMD_WR, FBG_CMD_WR_NOW} && drv_wdata[15];
				n_bad += int'(e);
				drv_ack <= 1'b1;
				drv_err <= e;
				drv_rdata <= exp_rd(drv_addr);
				@(posedge clk);
				drv_ack <= 1'b0;
			end
		end
	end
	// Classic single cycle; the wait ends only when ack is seen.
	task automatic wb(input logic w, input logic [7:0] ad,
		input logic [31:0] dw, output logic [31:0] dr);
		@(posedge clk);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, w, ad, dw};
		do @(posedge clk); while (wb_ack !== 1'b1);
		dr = wb_dat_r;
		{wb_cyc, wb_stb} <= 2'b00;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One object access; waits past the answer and any write gap.
	task automatic acc(input logic [15:0] idx, input logic [7:0] sub,
		input logic w, input logic pd, input logic [2:0] n,
		input logic [63:0] dw);
		wb(1'b1, 8'h00, {idx, sub, 5'h00, n}, t);
		wb(1'b1, 8'h04, dw[31:0], t);
		wb(1'b1, 8'h08, dw[63:32], t);
		wb(1'b1, 8'h0c, {5'h00, cob, 12'h000, 1'b0, pd, w, 1'b1}, t);
		do wb(1'b0, 8'h10, 32'h0000_0000, t); while (t[0] !== 1'b0);
		e = t[2];
		wb(1'b0, 8'h14, 32'h0000_0000, rd);
	endtask
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
	initial begin
		{wb_cyc, wb_stb, wb_we, rstn, wb_adr, wb_dat_w} = '0;
		{wb_sel, tx_type, tx_period_ms} = {4'hf, 8'hfe, 16'h0000};
		{error_cnt, checked, d} = '0;
		cob = 11'h1a6;
		void'($urandom(32'h1436));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		wb(1'b0, 8'h10, 32'h0000_0000, q);
		wb(1'b0, 8'h24, 32'h0000_0000, rd);
		chk({q, rd}, 64'h0);
		acc(16'h2155, 8'h00, 1'b0, 1'b0, 3'h0, 64'h0);
		chk(e, 1);
		// Initialization order first, then random reads, writes, commits.
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 16'h04c3 : (i == 1) ? 16'h0103 : 16'($urandom);
			v = (i == 0) ? 16'h0000 : (i == 1) ? 16'h08ac : 16'($urandom);
			p = i[0];
			acc(16'h2040, 8'h00, 1'b1, p, 3'h0, {48'h0, a});
			chk({last_cmd, last_addr}, {FBG_CMD_RD, a});
			acc(16'h2140, 8'h01, 1'b0, p, 3'h0, 64'h0);
			chk(rd[15:0], exp_rd(a));
			acc(16'h2050, 8'h01, 1'b1, p, 3'h0, {32'h0, a, v});
			chk({last_cmd, last_addr, last_dat}, {FBG_CMD_WR, a, v});
			acc(16'h2150, 8'h01, 1'b0, p, 3'h0, 64'h0);
			chk(rd[15:0], {15'h0000, v[15]});
			acc(16'h2060, 8'h01, 1'b1, p, 3'h0, {32'h0, SAVE});
			chk(last_cmd, FBG_CMD_ENT_RAM);
			acc(16'h2160, 8'h00, 1'b0, p, 3'h0, 64'h0);
			chk(rd[15:0], 16'h0000);
		end
		n0 = n_cmd;
		acc(16'h2070, 8'h01, 1'b1, 1'b1, 3'h0, {32'h0, SAVE ^ 32'h1});
		chk({e, n_cmd - n0}, 0);
		acc(16'h2070, 8'h01, 1'b1, 1'b0, 3'h0, {32'h0, SAVE});
		chk(last_cmd, FBG_CMD_ENT_ROM);
		// Four linked objects, then one batch with one refused entry.
		for (int k = 0; k < 4; k++) begin
			acc(16'h2180 + 16'(k), 8'h02, 1'b1, 1'b0, 3'h0,
				{48'h0, 16'h0300 + 16'(k)});
			d[16*k +: 16] = 16'($urandom) & 16'h7fff;
		end
		b = $urandom_range(3, 0);
		d[16*b+15] = 1'b1;
		{n0, nb} = {n_cmd, n_bad};
		acc(16'h2180, 8'h01, 1'b1, 1'b1, 3'h4, d);
		chk({last_cmd, last_addr, n_cmd - n0},
			{FBG_CMD_WR_NOW, 16'h0303, 32'h4});
		chk(n_bad - nb, 1);
		acc(16'h2155, 8'h00, 1'b0, 1'b0, 3'h0, 64'h0);
		chk(rd, exp_res(cob, 3'h1));
		wb(1'b0, 8'h18, 32'h0000_0000, q);
		wb(1'b0, 8'h1c, 32'h0000_0000, t);
		chk({q, t}, {exp_res(cob, 3'h1), 32'h1});
		for (int k = 0; k < 2; k++) begin
			n0 = n_cmd;
			acc(16'h2180 + 16'(k), 8'h01, 1'b1, 1'b1, k ? 3'h4 : 3'h0, d);
			chk({e, n_cmd - n0}, {1'b1, 32'h0});
		end
		// A service write to a linked object leaves the result alone.
		cob = cob + 11'h001;
		acc(16'h2182, 8'h01, 1'b1, 1'b0, 3'h0, {48'h0, 16'h1234});
		chk({last_cmd, last_addr, last_dat},
			{FBG_CMD_WR, 16'h0302, 16'h1234});
		acc(16'h2155, 8'h00, 1'b0, 1'b0, 3'h0, 64'h0);
		chk(rd, exp_res(cob - 11'h001, 3'h1));
		acc(16'h2183, 8'h01, 1'b0, 1'b0, 3'h0, 64'h0);
		chk(rd[15:0], exp_rd(16'h0303));
		acc(16'h2181, 8'h02, 1'b0, 1'b0, 3'h0, 64'h0);
		chk(rd[15:0], 16'h0301);
		wb(1'b1, 8'h0c, 32'h0000_0008, q);
		repeat (6) @(posedge clk);
		wb(1'b0, 8'h1c, 32'h0000_0000, q);
		chk(q, 2);
		tx_type <= 8'h01;
		tx_period_ms <= 16'h0001;
		repeat (10 * TICK) @(posedge clk);
		tx_period_ms <= 16'h0000;
		wb(1'b0, 8'h1c, 32'h0000_0000, q);
		chk(q >= 11 && q <= 13, 1);
		stop_test();
	end
endmodule
